// *** ssp_pkg.sv ***
// Constants and carrier types for the synchronous slave serial port.
// Assumes a byte-wide register port with three address bits.
package ssp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] TX_CTRL_OFF = 3'h0;
  localparam logic [2:0] RX_CTRL_OFF = 3'h1;
  localparam logic [2:0] TXDAT_OFF = 3'h2;
  localparam logic [2:0] RXDAT_OFF = 3'h3;
  localparam logic [2:0] IEN_OFF   = 3'h4;
  localparam logic [2:0] IFLG_OFF  = 3'h5;
  localparam logic [2:0] ICTL_OFF  = 3'h6;
  localparam logic [2:0] BAUD_OFF  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TX_CLKSRC_BIT   = 7;
  localparam int TX_NINE_EN_BIT  = 6;
  localparam int TX_EN_BIT       = 5;
  localparam int TX_SYNC_BIT     = 4;
  localparam int TX_TRMT_BIT     = 1;
  localparam int TX_NINE_DAT_BIT = 0;
  localparam int RC_PORT_EN_BIT  = 7;
  localparam int RC_NINE_EN_BIT  = 6;
  localparam int RC_SINGLE_BIT   = 5;
  localparam int RC_CONT_BIT     = 4;
  localparam int RC_OVERRUN_BIT  = 1;
  localparam int RC_NINE_DAT_BIT = 0;
  localparam int IE_RX_BIT       = 5;
  localparam int IE_TX_BIT       = 4;
  localparam int IF_RX_BIT       = 5;
  localparam int IF_TX_BIT       = 4;
  localparam int IC_GLOBAL_BIT   = 7;
  localparam int IC_PERIPH_BIT   = 6;
  localparam int BD_IDLE_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and character sizes
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG  = 4'h9;
  localparam int         FIFO_DEPTH = 2;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssp_char_t;

endpackage : ssp_pkg

// *** ssp_rx_fifo.sv ***
// Small receive queue of serial characters.
// Assumes push is never asserted while full; reset is synchronous.
`timescale 1ns/10ps
module ssp_rx_fifo #(
  parameter int DEPTH = 2
) (
  input  wire logic              ref_clk,
  input  wire logic              clr,
  input  wire logic              push,
  input  wire ssp_pkg::ssp_char_t push_char,
  input  wire logic              pop,
  output ssp_pkg::ssp_char_t     head_char,
  output logic                   empty,
  output logic                   full
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  ssp_pkg::ssp_char_t mem_reg [DEPTH];
  logic [PW-1:0]      wp_reg;
  logic [PW-1:0]      rp_reg;
  logic [CW-1:0]      cnt_reg;

  wire do_push = push && !full;
  wire do_pop  = pop && !empty;

  assign empty     = (cnt_reg == '0);
  assign full      = (cnt_reg == CW'(DEPTH));
  assign head_char = mem_reg[rp_reg];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem_reg[wp_reg] <= push_char;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) wp_reg <= bump(wp_reg);
      if (do_pop) rp_reg <= bump(rp_reg);
      cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule : ssp_rx_fifo

// *** ssp_slave_port.sv ***
// Synchronous slave serial port: registers, transmitter and receiver.
// Assumes the master drives the serial clock idle low; the pin inputs
// come from outside the clock domain and are synchronised here.
`timescale 1ns/10ps

module ssp_slave_port (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       core_sleep,
  output logic            core_wake,
  output logic            irq_vector,
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  output logic            serial_clock_pin_oe,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] tx_ctrl_reg;
  logic [7:0] rx_ctrl_reg;
  logic [7:0] ien_reg;
  logic [7:0] ictl_reg;
  logic [7:0] rdata_reg;
  logic       wake_reg;
  logic       vec_reg;

  wire wr_tx_ctrl = reg_wr && (reg_addr == ssp_pkg::TX_CTRL_OFF);
  wire wr_rx_ctrl = reg_wr && (reg_addr == ssp_pkg::RX_CTRL_OFF);
  wire wr_txdat   = reg_wr && (reg_addr == ssp_pkg::TXDAT_OFF);
  wire wr_ien     = reg_wr && (reg_addr == ssp_pkg::IEN_OFF);
  wire wr_ictl    = reg_wr && (reg_addr == ssp_pkg::ICTL_OFF);
  wire rd_rxdat   = reg_rd && (reg_addr == ssp_pkg::RXDAT_OFF);

  wire clk_src_sel  = tx_ctrl_reg[ssp_pkg::TX_CLKSRC_BIT];
  wire tx_nine_en   = tx_ctrl_reg[ssp_pkg::TX_NINE_EN_BIT];
  wire tx_en        = tx_ctrl_reg[ssp_pkg::TX_EN_BIT];
  wire sync_mode    = tx_ctrl_reg[ssp_pkg::TX_SYNC_BIT];
  wire tx_nine_dat  = tx_ctrl_reg[ssp_pkg::TX_NINE_DAT_BIT];
  wire port_en      = rx_ctrl_reg[ssp_pkg::RC_PORT_EN_BIT];
  wire rx_nine_en   = rx_ctrl_reg[ssp_pkg::RC_NINE_EN_BIT];
  wire single_rx_en = rx_ctrl_reg[ssp_pkg::RC_SINGLE_BIT];
  wire cont_rx_en   = rx_ctrl_reg[ssp_pkg::RC_CONT_BIT];
  wire rx_irq_en    = ien_reg[ssp_pkg::IE_RX_BIT];
  wire tx_irq_en    = ien_reg[ssp_pkg::IE_TX_BIT];
  wire glob_irq_en  = ictl_reg[ssp_pkg::IC_GLOBAL_BIT];
  wire per_irq_en   = ictl_reg[ssp_pkg::IC_PERIPH_BIT];

  // Slave only when clocked mode, port enabled and clock from outside
  wire slave_on = port_en && sync_mode && !clk_src_sel;
  wire port_clr = !rst_n || !port_en;
  wire tx_mode  = slave_on && !cont_rx_en && !single_rx_en;
  wire rx_mode  = slave_on && cont_rx_en;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_ctrl_reg <= ssp_pkg::CTRL_RST;
      rx_ctrl_reg <= ssp_pkg::CTRL_RST;
      ien_reg     <= ssp_pkg::CTRL_RST;
      ictl_reg    <= ssp_pkg::CTRL_RST;
    end else begin
      if (wr_tx_ctrl) tx_ctrl_reg <= reg_wdata;
      if (wr_rx_ctrl) rx_ctrl_reg <= reg_wdata;
      if (wr_ien) ien_reg <= reg_wdata;
      if (wr_ictl) ictl_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edges
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_prev_reg;
  logic sdi_meta_reg;
  logic sdi_sync_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sck_meta_reg <= serial_clock_pin_in;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      sdi_meta_reg <= serial_data_pin_in;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  // Leading edge rises, trailing edge falls
  wire sck_lead  = sck_sync_reg && !sck_prev_reg;
  wire sck_trail = !sck_sync_reg && sck_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: holding register and shifter
  ssp_pkg::ssp_char_t hold_reg;
  logic               hold_full_reg;
  logic [8:0]         tx_shift_reg;
  logic [3:0]         tx_cnt_reg;
  logic               tsr_busy_reg;
  logic               sdo_reg;
  logic               sdo_oe_reg;

  wire [3:0] tx_bits  = tx_nine_en ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
  wire       tx_load  = tx_mode && tx_en && hold_full_reg && !tsr_busy_reg;
  wire       tx_shift = tsr_busy_reg && sck_lead && (tx_cnt_reg < tx_bits);
  wire       tx_done  = tsr_busy_reg && sck_trail && (tx_cnt_reg == tx_bits);
  wire       tx_flag  = !hold_full_reg;

  always_ff @(posedge ref_clk) begin
    if (port_clr) begin
      hold_reg      <= '0;
      hold_full_reg <= 1'b0;
    end else if (wr_txdat) begin
      hold_reg      <= '{ninth: tx_nine_dat, data: reg_wdata};
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (port_clr || !tx_mode) begin
      tx_shift_reg <= '0;
      tx_cnt_reg   <= '0;
      tsr_busy_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= {hold_reg.ninth, hold_reg.data};
      tx_cnt_reg   <= '0;
      tsr_busy_reg <= 1'b1;
    end else if (tx_shift) begin
      tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
      tx_cnt_reg   <= tx_cnt_reg + 4'h1;
    end else if (tx_done) begin
      tsr_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (port_clr) begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= tx_mode && tx_en;
      if (tx_shift) sdo_reg <= tx_shift_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: shifter, overrun and queue
  logic [8:0]         rx_shift_reg;
  logic [3:0]         rx_cnt_reg;
  logic               overrun_reg;
  ssp_pkg::ssp_char_t rx_char;
  ssp_pkg::ssp_char_t head_char;
  logic               fifo_empty;
  logic               fifo_full;

  wire [3:0] rx_bits  = rx_nine_en ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
  wire       rx_on    = rx_mode && !overrun_reg;
  wire       rx_take  = rx_on && sck_trail;
  wire       rx_last  = rx_take && (rx_cnt_reg == rx_bits - 4'h1);
  wire       rx_push  = rx_last && !fifo_full;
  wire       rx_ovf   = rx_last && fifo_full;
  wire       rx_pop   = rd_rxdat && !fifo_empty;
  wire       rx_flag  = !fifo_empty;

  // Completed character, LSB first
  assign rx_char = rx_nine_en ? '{ninth: sdi_sync_reg, data: rx_shift_reg[8:1]}
                   : '{ninth: 1'b0, data: {sdi_sync_reg, rx_shift_reg[8:2]}};

  always_ff @(posedge ref_clk) begin
    if (port_clr || !rx_mode) begin
      rx_shift_reg <= '0;
      rx_cnt_reg   <= '0;
    end else if (rx_last) begin
      rx_shift_reg <= '0;
      rx_cnt_reg   <= '0;
    end else if (rx_take) begin
      rx_shift_reg <= {sdi_sync_reg, rx_shift_reg[8:1]};
      rx_cnt_reg   <= rx_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (port_clr || !cont_rx_en) begin
      overrun_reg <= 1'b0;
    end else if (rx_ovf) begin
      overrun_reg <= 1'b1;
    end
  end

  ssp_rx_fifo #(
    .DEPTH     (ssp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .clr       (port_clr),
    .push      (rx_push),
    .push_char (rx_char),
    .pop       (rx_pop),
    .head_char (head_char),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      ssp_pkg::TX_CTRL_OFF: begin
        rd_mux = tx_ctrl_reg;
        rd_mux[ssp_pkg::TX_TRMT_BIT] = !tsr_busy_reg;
      end
      ssp_pkg::RX_CTRL_OFF: begin
        rd_mux = rx_ctrl_reg;
        rd_mux[3:2] = 2'h0;
        rd_mux[ssp_pkg::RC_OVERRUN_BIT]  = overrun_reg;
        rd_mux[ssp_pkg::RC_NINE_DAT_BIT] = head_char.ninth;
      end
      ssp_pkg::TXDAT_OFF: rd_mux = 8'h00;
      ssp_pkg::RXDAT_OFF: rd_mux = head_char.data;
      ssp_pkg::IEN_OFF: begin
        rd_mux[ssp_pkg::IE_RX_BIT] = rx_irq_en;
        rd_mux[ssp_pkg::IE_TX_BIT] = tx_irq_en;
      end
      ssp_pkg::IFLG_OFF: begin
        rd_mux[ssp_pkg::IF_RX_BIT] = rx_flag;
        rd_mux[ssp_pkg::IF_TX_BIT] = tx_flag;
      end
      ssp_pkg::ICTL_OFF: begin
        rd_mux[ssp_pkg::IC_GLOBAL_BIT] = glob_irq_en;
        rd_mux[ssp_pkg::IC_PERIPH_BIT] = per_irq_en;
      end
      ssp_pkg::BAUD_OFF: rd_mux[ssp_pkg::BD_IDLE_BIT] = (rx_cnt_reg == 4'h0);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake and interrupt requests to the core
  wire rx_req = rx_flag && rx_irq_en;
  wire tx_req = tx_flag && tx_irq_en && per_irq_en;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_reg <= 1'b0;
      vec_reg  <= 1'b0;
    end else begin
      wake_reg <= core_sleep && (rx_req || tx_req);
      vec_reg  <= (rx_req || tx_req) && per_irq_en && glob_irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata            = rdata_reg;
  assign core_wake            = wake_reg;
  assign irq_vector           = vec_reg;
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe  = 1'b0;
  assign serial_data_pin_out  = sdo_reg;
  assign serial_data_pin_oe   = sdo_oe_reg;

endmodule : ssp_slave_port

// *** sssp_chk.sv ***
// Port checker for the synchronous slave serial port.
// Assumes it is bound to ssp_slave_port and sees only its ports.
`timescale 1ns/10ps
module sssp_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_sleep,
  input wire logic       core_wake,
  input wire logic       irq_vector,
  input wire logic       serial_clock_pin_in,
  input wire logic       serial_clock_pin_out,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_data_pin_in,
  input wire logic       serial_data_pin_out,
  input wire logic       serial_data_pin_oe
);
  logic [7:0] tx_reg, rc_reg, ie_reg, ic_reg;
  logic       tx_mode;
  logic       req;

  // Shadow copies of the control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
      rc_reg <= 8'h00;
      ie_reg <= 8'h00;
      ic_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ssp_pkg::TX_CTRL_OFF) tx_reg <= reg_wdata;
      if (reg_addr == ssp_pkg::RX_CTRL_OFF) rc_reg <= reg_wdata;
      if (reg_addr == ssp_pkg::IEN_OFF) ie_reg <= reg_wdata;
      if (reg_addr == ssp_pkg::ICTL_OFF) ic_reg <= reg_wdata;
    end
  end
  assign tx_mode = rc_reg[7] & tx_reg[4] & ~tx_reg[7] & tx_reg[5] & ~rc_reg[5] & ~rc_reg[4];
  assign req = ie_reg[5] | (ie_reg[4] & ic_reg[6]);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_clk_pin_released: assert property (!serial_clock_pin_oe && !serial_clock_pin_out)
    else $error("clock pin driven by slave");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_txdat_reads_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == ssp_pkg::TXDAT_OFF |-> reg_rdata == 8'h00)
    else $error("transmit data register readable");
  a_drive_only_tx: assert property (serial_data_pin_oe |-> $past(tx_mode))
    else $error("data pin driven outside transmit mode");
  a_oe_follows_mode: assert property (tx_mode [*3] |=> serial_data_pin_oe)
    else $error("data pin not driven in transmit mode");
  a_wake_needs_sleep: assert property (core_wake |-> $past(core_sleep) && $past(req))
    else $error("wake without sleep or enable");
  a_vector_needs_gie: assert property (irq_vector |-> $past(ic_reg[7] & ic_reg[6] & req))
    else $error("vector without enables");
  a_sdo_holds_idle: assert property (
    (!serial_clock_pin_in && !reg_wr) [*6] |=> $stable(serial_data_pin_out))
    else $error("data out moved without leading edge");

  cover property (core_wake);
  cover property (irq_vector);
  cover property (serial_data_pin_oe ##1 !serial_data_pin_oe);
endmodule : sssp_chk

bind ssp_slave_port sssp_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_sleep(core_sleep), .core_wake(core_wake), .irq_vector(irq_vector),
  .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe));

// *** sssp_master.sv ***
// External synchronous master model that makes the serial clock.
// Assumes the bench calls xfer once per character.
`timescale 1ns/10ps
module sssp_master (
  output logic     link_clk,
  output logic     dq,
  input wire logic sdo
);
  initial begin
    link_clk = 1'b0;
    dq = 1'b1;
  end

  // One character LSB first; clock idles low, gap slows the master
  task automatic xfer(input logic [8:0] tx, input int n, input real gap,
                      output logic [8:0] rx);
    rx = 9'h000;
    #3.3;
    for (int i = 0; i < n; i++) begin
      link_clk = 1'b1;
      dq = tx[i];
      #62.5;
      link_clk = 1'b0;
      rx[i] = sdo;
      #(62.5 + gap);
    end
    dq = ~dq;
  endtask : xfer
endmodule : sssp_master

// *** sync_slave_serial_port_bench.sv ***
// Self-checking bench for the synchronous slave serial port.
// Assumes ssp_pkg, sssp_master and sssp_chk are compiled first.
`timescale 1ns/10ps
module sync_slave_serial_port_bench;
  logic       ref_clk, rst_n, reg_wr, reg_rd, core_sleep, core_wake, irq_vector;
  logic       link_clk, dq, sdo, sdo_oe, line_dat;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rb, ctl;
  logic [8:0] got, ch, q [4];
  int         mismatches, checks, cycles, seed, n9;

  assign line_dat = sdo_oe ? sdo : dq;
  ssp_slave_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_sleep(core_sleep), .core_wake(core_wake), .irq_vector(irq_vector),
    .serial_clock_pin_in(link_clk), .serial_clock_pin_out(), .serial_clock_pin_oe(),
    .serial_data_pin_in(line_dat), .serial_data_pin_out(sdo), .serial_data_pin_oe(sdo_oe));
  sssp_master m (.link_clk(link_clk), .dq(dq), .sdo(line_dat));

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] mask9(logic [8:0] v, logic nine);
    return nine ? v : {1'b0, v[7:0]};
  endfunction : mask9
  function automatic logic [7:0] rc_exp(logic [7:0] c, logic overrun_error_flag, logic n9d);
    return {c[7:4], 2'b00, overrun_error_flag, n9d};
  endfunction : rc_exp
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk_val(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_pin(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: pin %b expected %b", $time, g, e);
    end
  endtask : chk_pin
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9e3948f7;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    core_sleep = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ssp_pkg::TXDAT_OFF, rb);
    chk_val({1'b0, rb}, 9'h000);
    wr(ssp_pkg::ICTL_OFF, 8'hc0);
    wr(ssp_pkg::IEN_OFF, 8'h10);
    wr(ssp_pkg::RX_CTRL_OFF, 8'h80);
    // Transmit, 8 and 9 bit, prompt and slow master
    for (int k = 0; k < 6; k++) begin
      n9 = k % 2;
      ch = mask9(9'($random(seed)), n9[0]);
      wr(ssp_pkg::TX_CTRL_OFF, {1'b0, n9[0], 5'h18, ch[8]});
      wr(ssp_pkg::TXDAT_OFF, ch[7:0]);
      repeat (4) @(posedge ref_clk);
      chk_pin(sdo_oe, 1'b1);
      m.xfer(9'h000, 8 + n9, (k > 3) ? 500.0 : 0.0, got);
      chk_val(got, ch);
    end
    chk_pin(irq_vector, 1'b1);
    // Two characters queued while asleep
    @(posedge ref_clk);
    core_sleep <= 1'b1;
    ch = mask9(9'($random(seed)), 1'b0);
    wr(ssp_pkg::TX_CTRL_OFF, 8'h30);
    wr(ssp_pkg::TXDAT_OFF, ch[7:0]);
    @(posedge ref_clk);
    wr(ssp_pkg::TXDAT_OFF, 8'h5a);
    repeat (4) @(posedge ref_clk);
    chk_pin(core_wake, 1'b0);
    m.xfer(9'h000, 8, 0.0, got);
    chk_val(got, ch);
    repeat (8) @(posedge ref_clk);
    chk_pin(core_wake, 1'b1);
    m.xfer(9'h000, 8, 0.0, got);
    chk_val(got, 9'h05a);
    // Receive during sleep, single enable random
    wr(ssp_pkg::IEN_OFF, 8'h20);
    for (int k = 0; k < 6; k++) begin
      n9 = k % 2;
      ctl = {1'b1, n9[0], 1'($random(seed)), 5'h10};
      wr(ssp_pkg::RX_CTRL_OFF, ctl);
      wr(ssp_pkg::ICTL_OFF, {n9[0], 7'h40});
      ch = mask9(9'($random(seed)), n9[0]);
      m.xfer(ch, 8 + n9, 0.0, got);
      repeat (10) @(posedge ref_clk);
      chk_pin(core_wake, 1'b1);
      chk_pin(irq_vector, n9[0]);
      chk_pin(sdo_oe, 1'b0);
      rd(ssp_pkg::RX_CTRL_OFF, rb);
      chk_val({1'b0, rb}, {1'b0, rc_exp(ctl, 1'b0, ch[8])});
      rd(ssp_pkg::RXDAT_OFF, rb);
      chk_val({1'b0, rb}, {1'b0, ch[7:0]});
    end
    // Overrun: two kept, third flags, fourth blocked
    @(posedge ref_clk);
    core_sleep <= 1'b0;
    wr(ssp_pkg::RX_CTRL_OFF, 8'h90);
    for (int k = 0; k < 4; k++) begin
      q[k] = mask9(9'($random(seed)), 1'b0);
      m.xfer(q[k], 8, 0.0, got);
    end
    repeat (10) @(posedge ref_clk);
    rd(ssp_pkg::RX_CTRL_OFF, rb);
    chk_val({1'b0, rb}, {1'b0, rc_exp(8'h90, 1'b1, 1'b0)});
    for (int k = 0; k < 2; k++) begin
      rd(ssp_pkg::RXDAT_OFF, rb);
      chk_val({1'b0, rb}, q[k]);
    end
    rd(ssp_pkg::IFLG_OFF, rb);
    chk_val({1'b0, rb}, 9'h010);
    wr(ssp_pkg::RX_CTRL_OFF, 8'h80);
    rd(ssp_pkg::RX_CTRL_OFF, rb);
    chk_val({1'b0, rb}, 9'h080);
    wr(ssp_pkg::RX_CTRL_OFF, 8'h90);
    ch = mask9(9'($random(seed)), 1'b0);
    m.xfer(ch, 8, 0.0, got);
    repeat (10) @(posedge ref_clk);
    rd(ssp_pkg::RXDAT_OFF, rb);
    chk_val({1'b0, rb}, ch);
    finish_test();
  end
endmodule : sync_slave_serial_port_bench
